// ---- core/asf_pkg.sv ----
// Purpose: shared constants and types for the alu status flag block
// Assumes: 8-bit data path, 32-bit apb data bus
// Notes: flag positions are those of the status byte
package asf_pkg;
    // ------------------------------------------------------------
    // data and bus widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int FLAG_W = 5;
    localparam int BIT_SEL_W = 3;
    localparam int NIB_W = 4;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ALU_CONDITION_FLAGS_OFS = 8'h00;
    localparam logic [7:0] LAST_RESULT_OFS = 8'h04;
    localparam logic [7:0] OP_COUNT_OFS = 8'h08;

    // ------------------------------------------------------------
    // flag positions inside the status byte
    // ------------------------------------------------------------
    localparam int CARRY_BIT = 0;
    localparam int NIBBLE_CARRY_BIT = 1;
    localparam int ZERO_BIT = 2;
    localparam int SIGNED_WRAP_BIT = 3;
    localparam int NEGATIVE_BIT = 4;

    // ------------------------------------------------------------
    // reset values and flag update masks
    // ------------------------------------------------------------
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [4:0] MASK_NONE = 5'h00;
    localparam logic [4:0] MASK_ALL = 5'h1F;
    localparam logic [4:0] MASK_ZERO_NEG = 5'h14;
    localparam logic [4:0] MASK_ZERO = 5'h04;

    // ------------------------------------------------------------
    // operations the core may present
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_ADD,
        OP_SUB,
        OP_AND,
        OP_IOR,
        OP_XOR,
        OP_CLEAR_FILE,
        OP_FILE_TO_FILE_MOVE,
        OP_ACCUMULATOR_TO_FILE_MOVE,
        OP_BIT_CLEAR,
        OP_BIT_SET,
        OP_NIBBLE_SWAP
    } asf_op_t;
endpackage

// ---- core/asf_alu_if.sv ----
// Purpose: carries one operation between the flag register and the alu
// Assumes: purely combinational exchange within one cycle
// Notes: mask marks which of the five flags the operation updates
`timescale 1ns/1ns
`default_nettype none
interface asf_alu_if;
    asf_pkg::asf_op_t op;
    logic [7:0] opnd_a;
    logic [7:0] opnd_b;
    logic [2:0] bit_sel;
    logic [7:0] result;
    logic [4:0] flags;
    logic [4:0] mask;

    modport core (output op, output opnd_a, output opnd_b, output bit_sel,
                  input result, input flags, input mask);
    modport alu (input op, input opnd_a, input opnd_b, input bit_sel,
                 output result, output flags, output mask);
endinterface
`default_nettype wire

// ---- core/asf_alu.sv ----
// Purpose: computes an operation result and its condition flags
// Assumes: operands valid in the same cycle
// Notes: purely combinational
`timescale 1ns/1ns
`default_nettype none
module asf_alu (
    // operation exchange
    asf_alu_if.alu bus
);
    // ------------------------------------------------------------
    // adder shared by add and subtract
    // ------------------------------------------------------------
    logic is_sub;
    logic [7:0] addend;
    logic [4:0] low_sum;
    logic [7:0] low7_sum;
    logic [8:0] full_sum;

    assign is_sub = (bus.op == asf_pkg::OP_SUB);
    // subtract adds the two's complement, so carries mean "no borrow"
    assign addend = is_sub ? ~bus.opnd_b : bus.opnd_b;
    assign low_sum = {1'b0, bus.opnd_a[3:0]} + {1'b0, addend[3:0]} + {4'h0, is_sub};
    assign low7_sum = {1'b0, bus.opnd_a[6:0]} + {1'b0, addend[6:0]} + {7'h00, is_sub};
    assign full_sum = {1'b0, bus.opnd_a} + {1'b0, addend} + {8'h00, is_sub};

    always_comb begin
        bus.result = asf_pkg::RESULT_RESET;
        bus.mask = asf_pkg::MASK_NONE;
        case (bus.op)
            asf_pkg::OP_ADD, asf_pkg::OP_SUB: begin
                bus.result = full_sum[7:0];
                bus.mask = asf_pkg::MASK_ALL;
            end
            asf_pkg::OP_AND: begin
                bus.result = bus.opnd_a & bus.opnd_b;
                bus.mask = asf_pkg::MASK_ZERO_NEG;
            end
            asf_pkg::OP_IOR: begin
                bus.result = bus.opnd_a | bus.opnd_b;
                bus.mask = asf_pkg::MASK_ZERO_NEG;
            end
            asf_pkg::OP_XOR: begin
                bus.result = bus.opnd_a ^ bus.opnd_b;
                bus.mask = asf_pkg::MASK_ZERO_NEG;
            end
            asf_pkg::OP_CLEAR_FILE: begin
                // only zero is touched, so the other flags stay put
                bus.result = asf_pkg::RESULT_RESET;
                bus.mask = asf_pkg::MASK_ZERO;
            end
            asf_pkg::OP_FILE_TO_FILE_MOVE, asf_pkg::OP_ACCUMULATOR_TO_FILE_MOVE: begin
                bus.result = bus.opnd_a;
            end
            asf_pkg::OP_BIT_CLEAR: begin
                bus.result = bus.opnd_a & ~(8'h01 << bus.bit_sel);
            end
            asf_pkg::OP_BIT_SET: begin
                bus.result = bus.opnd_a | (8'h01 << bus.bit_sel);
            end
            asf_pkg::OP_NIBBLE_SWAP: begin
                bus.result = {bus.opnd_a[3:0], bus.opnd_a[7:4]};
            end
            default: begin
                bus.result = asf_pkg::RESULT_RESET;
                bus.mask = asf_pkg::MASK_NONE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // flag values, used only where the mask allows
    // ------------------------------------------------------------
    always_comb begin
        bus.flags = asf_pkg::FLAGS_RESET;
        bus.flags[asf_pkg::CARRY_BIT] = full_sum[8];
        bus.flags[asf_pkg::NIBBLE_CARRY_BIT] = low_sum[4];
        bus.flags[asf_pkg::ZERO_BIT] = (bus.result == asf_pkg::RESULT_RESET);
        // wrap when carry into the sign differs from carry out of it
        bus.flags[asf_pkg::SIGNED_WRAP_BIT] = low7_sum[7] ^ full_sum[8];
        bus.flags[asf_pkg::NEGATIVE_BIT] = bus.result[7];
    end
endmodule
`default_nettype wire

// ---- core/alu_status_flags.sv ----
// Purpose: holds the alu condition flag byte and applies instruction results
// Assumes: core presents at most one operation per pclk cycle
// Notes: software reaches the flags over apb with zero wait states
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module alu_status_flags #(
    parameter int DATA_W = asf_pkg::DATA_W
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [asf_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // instruction execution
    input wire logic ex_valid,
    input wire logic [3:0] ex_op,
    input wire logic [7:0] ex_opnd_a,
    input wire logic [7:0] ex_opnd_b,
    input wire logic [2:0] ex_bit_sel,
    input wire logic ex_src_is_flags,
    input wire logic ex_dest_is_flags,
    // results
    output logic [7:0] ex_result,
    output logic [7:0] condition_flags
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (DATA_W != asf_pkg::DATA_W) begin : g_bad_width
        $error("alu_status_flags serves an 8-bit data path only");
    end

    // the flag field and the negative flag position must fit inside the status byte
    if (asf_pkg::FLAG_W > DATA_W) begin : g_bad_flag_width
        $error("alu_status_flags flag field is wider than the data path");
    end

    if (asf_pkg::NEGATIVE_BIT >= asf_pkg::FLAG_W) begin : g_bad_flag_pos
        $error("alu_status_flags flag position lies outside the flag field");
    end

    // the three words must not alias, or one read would shadow another
    if (asf_pkg::LAST_RESULT_OFS == asf_pkg::ALU_CONDITION_FLAGS_OFS ||
        asf_pkg::OP_COUNT_OFS == asf_pkg::ALU_CONDITION_FLAGS_OFS ||
        asf_pkg::OP_COUNT_OFS == asf_pkg::LAST_RESULT_OFS) begin : g_bad_map
        $error("alu_status_flags register offsets overlap");
    end

    // every word must sit on a 32-bit boundary of the bus
    if (asf_pkg::ALU_CONDITION_FLAGS_OFS[1:0] != 2'h0 ||
        asf_pkg::LAST_RESULT_OFS[1:0] != 2'h0 ||
        asf_pkg::OP_COUNT_OFS[1:0] != 2'h0) begin : g_bad_align
        $error("alu_status_flags register offsets must be word aligned");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [4:0] flags_reg;
    logic [4:0] flags_next;
    logic [7:0] result_reg;
    logic [7:0] result_next;
    logic [31:0] op_count_reg;
    logic [31:0] op_count_next;
    logic [7:0] status_byte;
    logic apb_write;
    logic apb_access;
    logic addr_hit;
    logic flags_write;
    asf_alu_if alu_bus ();

    // ------------------------------------------------------------
    // decode and update helpers
    // ------------------------------------------------------------
    logic apb_setup;
    logic read_setup;
    logic sel_flags;
    logic sel_result;
    logic sel_count;
    logic [31:0] read_word;
    logic [4:0] bus_flags;
    logic [4:0] base_flags;
    logic [4:0] merged_flags;
    logic op_sets_flags;
    logic dest_load;

    // ------------------------------------------------------------
    // alu and operand selection
    // ------------------------------------------------------------
    asf_alu u_alu (
        .bus(alu_bus)
    );

    // upper three bits never stored, so they always read zero
    assign status_byte = {3'h0, flags_reg};

    // the flag byte may stand in for the first operand
    assign alu_bus.op = asf_pkg::asf_op_t'(ex_op);
    assign alu_bus.opnd_a = ex_src_is_flags ? status_byte : ex_opnd_a;
    assign alu_bus.opnd_b = ex_opnd_b;
    assign alu_bus.bit_sel = ex_bit_sel;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign apb_setup = psel & ~penable;
    assign apb_access = psel & penable;
    assign apb_write = apb_access & pwrite;
    // no wait states: every word answers in its first access cycle
    assign pready = 1'b1;
    assign sel_flags = (paddr == asf_pkg::ALU_CONDITION_FLAGS_OFS);
    assign sel_result = (paddr == asf_pkg::LAST_RESULT_OFS);
    assign sel_count = (paddr == asf_pkg::OP_COUNT_OFS);
    assign addr_hit = sel_flags | sel_result | sel_count;
    // writes to read-only words drop silently; only unmapped holes raise an error
    assign pslverr = apb_access & ~addr_hit;
    assign flags_write = apb_write & sel_flags;
    assign bus_flags = pwdata[asf_pkg::FLAG_W-1:0];
    assign read_setup = apb_setup & ~pwrite;

    // ------------------------------------------------------------
    // flag update decisions
    // ------------------------------------------------------------
    // a same-cycle bus write is only the base that an instruction overrides
    assign base_flags = flags_write ? bus_flags : flags_reg;
    // an op that owns any arithmetic flag blocks the byte write to all five
    assign op_sets_flags = (alu_bus.mask != asf_pkg::MASK_NONE);
    // moves, bit ops and swap into the status byte land their result bits
    assign dest_load = ex_valid & ex_dest_is_flags & ~op_sets_flags;

    // flags the op does not own keep their value, so a clear only sets zero
    for (genvar i = 0; i < asf_pkg::FLAG_W; i++) begin : g_flag_merge
        assign merged_flags[i] = alu_bus.mask[i] ? alu_bus.flags[i] : base_flags[i];
    end

    always_comb begin
        flags_next = base_flags;
        if (dest_load) begin
            flags_next = alu_bus.result[asf_pkg::FLAG_W-1:0];
        end else if (ex_valid) begin
            flags_next = merged_flags;
        end
    end

    // moves, bit ops and swap carry an empty mask, so software edits stay intact unless the status byte is their destination
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= asf_pkg::FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ------------------------------------------------------------
    // last result and operation count
    // ------------------------------------------------------------
    assign result_next = ex_valid ? alu_bus.result : result_reg;
    // a free-running count lets software see that operations arrive; it wraps
    assign op_count_next = ex_valid ? op_count_reg + 32'h00000001 : op_count_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= asf_pkg::RESULT_RESET;
        end else begin
            result_reg <= result_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_count_reg <= 32'h00000000;
        end else begin
            op_count_reg <= op_count_next;
        end
    end

    // ------------------------------------------------------------
    // apb read data
    // ------------------------------------------------------------
    always_comb begin
        read_word = 32'h00000000;
        case (paddr)
            asf_pkg::ALU_CONDITION_FLAGS_OFS: read_word = {24'h000000, status_byte};
            asf_pkg::LAST_RESULT_OFS: read_word = {24'h000000, result_reg};
            asf_pkg::OP_COUNT_OFS: read_word = op_count_reg;
            default: read_word = 32'h00000000;
        endcase
    end

    // taken in the setup cycle so the data output is a flip-flop; the cost is that
    // a flag change at the setup-to-access edge is not seen by that read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (read_setup) begin
            prdata <= read_word;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign ex_result = result_reg;
    assign condition_flags = status_byte;
endmodule
`default_nettype wire

// ---- bench/asf_chk.sv ----
// Purpose: watches flag updates and results at the top ports
// Assumes: one pclk domain, presetn async active low
// Notes: a same-cycle apb flag write is left out of the keep check
`timescale 1ns/1ns
`default_nettype none
module asf_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [asf_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // instruction execution
    input wire logic ex_valid,
    input wire logic [3:0] ex_op,
    input wire logic [7:0] ex_opnd_a,
    input wire logic [7:0] ex_opnd_b,
    input wire logic [2:0] ex_bit_sel,
    input wire logic ex_src_is_flags,
    input wire logic ex_dest_is_flags,
    // results
    input wire logic [7:0] ex_result,
    input wire logic [7:0] condition_flags
);
    logic [8:0] add_sum;
    logic [8:0] sub_sum;
    logic [4:0] sub_nib;
    logic add_go;
    logic sub_go;
    assign add_sum = {1'b0, ex_opnd_a} + {1'b0, ex_opnd_b};
    assign sub_sum = {1'b0, ex_opnd_a} + {1'b0, ~ex_opnd_b} + 9'h001;
    assign sub_nib = {1'b0, ex_opnd_a[3:0]} + {1'b0, ~ex_opnd_b[3:0]} + 5'h01;
    assign add_go = ex_valid && !ex_src_is_flags && ex_op == asf_pkg::OP_ADD;
    assign sub_go = ex_valid && !ex_src_is_flags && ex_op == asf_pkg::OP_SUB;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_top_zero;
        condition_flags[7:5] == 3'h0;
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("top flag bits set");
    property p_add_carry;
        add_go |=> condition_flags[0] == $past(add_sum[8]);
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add carry wrong");
    property p_sub_borrow;
        sub_go |=> condition_flags[0] == $past(sub_sum[8]) && condition_flags[1] == $past(sub_nib[4]);
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("sub borrow wrong");
    property p_wrap;
        add_go |=> condition_flags[3] ==
            ($past(ex_opnd_a[7]) == $past(ex_opnd_b[7]) && ex_result[7] != $past(ex_opnd_a[7]));
    endproperty
    a_wrap: assert property (p_wrap) else $error("signed wrap wrong");
    property p_zero;
        add_go || sub_go |=> condition_flags[2] == (ex_result == 8'h00) && condition_flags[4] == ex_result[7];
    endproperty
    a_zero: assert property (p_zero) else $error("zero or negative wrong");
    property p_clear;
        ex_valid && ex_op == asf_pkg::OP_CLEAR_FILE && ex_dest_is_flags
            |=> condition_flags == ($past(condition_flags) | 8'h04);
    endproperty
    a_clear: assert property (p_clear) else $error("clear of flags wrong");
    property p_keep;
        ex_valid && !ex_dest_is_flags && ex_op >= asf_pkg::OP_FILE_TO_FILE_MOVE && !(psel && pwrite)
            |=> $stable(condition_flags);
    endproperty
    a_keep: assert property (p_keep) else $error("flags changed by move");
    property p_dest_move;
        ex_valid && ex_dest_is_flags && !ex_src_is_flags && ex_op == asf_pkg::OP_ACCUMULATOR_TO_FILE_MOVE
            |=> condition_flags[4:0] == $past(ex_opnd_a[4:0]);
    endproperty
    a_dest_move: assert property (p_dest_move) else $error("move into flags wrong");
    property p_dest_logic;
        ex_valid && ex_dest_is_flags && ex_op == asf_pkg::OP_AND && !(psel && pwrite)
            |=> condition_flags[3] == $past(condition_flags[3])
            && condition_flags[1:0] == $past(condition_flags[1:0]);
    endproperty
    a_dest_logic: assert property (p_dest_logic) else $error("logic op wrote flags it does not own");
endmodule
bind alu_status_flags asf_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ex_valid, .ex_op, .ex_opnd_a, .ex_opnd_b, .ex_bit_sel, .ex_src_is_flags,
    .ex_dest_is_flags, .ex_result, .condition_flags);
`default_nettype wire

// ---- bench/alu_status_flags_bench.sv ----
// Purpose: self-checking bench for alu_status_flags
// Assumes: apb answers with no fixed latency, ops taken at the edge
// Notes: flag expectations come from a local reference, not the alu
`timescale 1ns/1ns
`default_nettype none
module alu_status_flags_bench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, ex_valid = 1'b0, ex_src_is_flags = 1'b0, ex_dest_is_flags = 1'b0;
    logic [3:0] ex_op = 4'h0;
    logic [7:0] ex_opnd_a = 8'h00, ex_opnd_b = 8'h00, ex_result, condition_flags;
    logic [2:0] ex_bit_sel = 3'h0;
    int errors = 0, check_count = 0, n_ops = 0;
    alu_status_flags i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .ex_valid, .ex_op, .ex_opnd_a, .ex_opnd_b, .ex_bit_sel, .ex_src_is_flags,
        .ex_dest_is_flags, .ex_result, .condition_flags);
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", 32'h1, {31'h0, pready});
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic fchk(input logic [7:0] e);
        chk("flags", {24'h0, e}, {24'h0, condition_flags});
    endtask
    task automatic op(input asf_pkg::asf_op_t o, input logic [7:0] a, b, input logic [2:0] s, input logic src, dst);
        @(posedge pclk);
        ex_valid <= 1'b1;
        ex_op <= o;
        ex_opnd_a <= a;
        ex_opnd_b <= b;
        ex_bit_sel <= s;
        ex_src_is_flags <= src;
        ex_dest_is_flags <= dst;
        @(posedge pclk);
        ex_valid <= 1'b0;
        n_ops++;
        #1;
    endtask
    // {result, N, wrap, Z, nibble carry, C}; subtraction adds the inverted operand plus one
    function automatic logic [12:0] ref_arith(input logic sub, input logic [7:0] a, b);
        logic [7:0] bb;
        logic [8:0] s;
        logic [4:0] n;
        bb = sub ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + {8'h00, sub};
        n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
        return {s[7:0], s[7], (a[7] == bb[7]) && (s[7] != a[7]), s[7:0] == 8'h00, n[4], s[8]};
    endfunction
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        apb(1'b0, asf_pkg::ALU_CONDITION_FLAGS_OFS, 32'h0);
        chk("reset flags", 32'h0, rd);
        apb(1'b1, asf_pkg::ALU_CONDITION_FLAGS_OFS, 32'hFFFFFFFF);
        apb(1'b0, asf_pkg::ALU_CONDITION_FLAGS_OFS, 32'h0);
        chk("flags rw", 32'h1F, rd);
        fchk(8'h1F);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
    endtask
    task automatic t_arith();
        logic [7:0] ta [6] = '{8'h0F, 8'hFF, 8'h7F, 8'h80, 8'h10, 8'h00};
        logic [7:0] tb [6] = '{8'h01, 8'h01, 8'h01, 8'h80, 8'h01, 8'h01};
        logic [12:0] e;
        for (int i = 0; i < 12; i++) begin
            e = ref_arith(i[0], ta[i/2], tb[i/2]);
            op(i[0] ? asf_pkg::OP_SUB : asf_pkg::OP_ADD, ta[i/2], tb[i/2], 3'h0, 1'b0, 1'b0);
            chk("result", {24'h0, e[12:5]}, {24'h0, ex_result});
            fchk({3'h0, e[4:0]});
        end
    endtask
    task automatic t_logic();
        apb(1'b1, asf_pkg::ALU_CONDITION_FLAGS_OFS, 32'h0B);
        op(asf_pkg::OP_AND, 8'hF0, 8'h0F, 3'h0, 1'b0, 1'b0);
        fchk(8'h0F);
        op(asf_pkg::OP_IOR, 8'h80, 8'h01, 3'h0, 1'b0, 1'b0);
        fchk(8'h1B);
        op(asf_pkg::OP_XOR, 8'h55, 8'h55, 3'h0, 1'b0, 1'b0);
        fchk(8'h0F);
    endtask
    task automatic t_dest();
        op(asf_pkg::OP_ADD, 8'h7F, 8'h01, 3'h0, 1'b0, 1'b1);
        fchk(8'h1A);
        op(asf_pkg::OP_AND, 8'hFF, 8'h80, 3'h0, 1'b0, 1'b1);
        fchk(8'h1A);
        apb(1'b1, asf_pkg::ALU_CONDITION_FLAGS_OFS, 32'h1B);
        op(asf_pkg::OP_CLEAR_FILE, 8'h00, 8'h00, 3'h0, 1'b0, 1'b1);
        fchk(8'h1F);
    endtask
    task automatic t_moves();
        op(asf_pkg::OP_BIT_CLEAR, 8'h00, 8'h00, 3'h4, 1'b1, 1'b1);
        fchk(8'h0F);
        op(asf_pkg::OP_BIT_SET, 8'h00, 8'h00, 3'h5, 1'b1, 1'b1);
        fchk(8'h0F);
        op(asf_pkg::OP_NIBBLE_SWAP, 8'h00, 8'h00, 3'h0, 1'b1, 1'b0);
        chk("swap", 32'hF0, {24'h0, ex_result});
        op(asf_pkg::OP_ACCUMULATOR_TO_FILE_MOVE, 8'h35, 8'h00, 3'h0, 1'b0, 1'b1);
        fchk(8'h15);
        op(asf_pkg::OP_FILE_TO_FILE_MOVE, 8'h0A, 8'h00, 3'h0, 1'b0, 1'b1);
        fchk(8'h0A);
        apb(1'b1, asf_pkg::LAST_RESULT_OFS, 32'hFF);
        apb(1'b0, asf_pkg::LAST_RESULT_OFS, 32'h0);
        chk("last result", 32'h0A, rd);
        apb(1'b0, asf_pkg::OP_COUNT_OFS, 32'h0);
        chk("op count", n_ops, rd);
    endtask
    initial begin
        forever #25 pclk = ~pclk;
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_arith();
        t_logic();
        t_dest();
        t_moves();
        end_sim();
    end
    // the whole run needs under 100 cycles; the 4000-cycle limit leaves wide margin
    initial begin
        #200000;
        errors++;
        end_sim();
    end
endmodule
`default_nettype wire
